// >>> hw/rtc_consts.vh
// constants for the serial timekeeper: command fields, register indices, field layouts, timing
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH
`define CMD_START_BIT 7
`define CMD_RAM_BIT 6
`define CMD_READ_BIT 0
`define ADDR_BURST 5'h1f
`define IDX_SEC 5'h00
`define IDX_MIN 5'h01
`define IDX_HR 5'h02
`define IDX_DATE 5'h03
`define IDX_MONTH 5'h04
`define IDX_DAY 5'h05
`define IDX_YEAR 5'h06
`define IDX_CTRL 5'h07
`define IDX_CHARGER 5'h08
`define CLK_BURST_LAST 3'h7
`define RAM_WORDS 31
`define RAM_LAST 5'h1e
`define HALT_BIT 7
`define LOCK_BIT 7
`define MODE12_BIT 7
`define PM_BIT 5
`define CHARGER_RESET 8'h5c
`define SEC_RESET 8'h80
`define DATE_RESET 8'h01
`define MONTH_RESET 8'h01
`define DAY_RESET 8'h01
`define LOCK_RESET 8'h80
`define REF_HZ 10000000
`define TICK_US 1000000
`define BIT_LAST 3'h7
`endif

// >>> hw/rtc_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module rtc_fifo
#(
  parameter WIDTH = 13,
  parameter DEPTH = 16,
  parameter AW = 4
)
(
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr;
reg [AW-1:0] rd_ptr;
reg [AW:0] count;
wire do_wr;
wire do_rd;
assign in_ready = (count != DEPTH[AW:0]);
assign out_valid = (count != {(AW+1){1'b0}});
assign out_data = mem[rd_ptr];
assign do_wr = in_valid && in_ready;
assign do_rd = out_valid && out_ready;
always @(posedge clk)
begin
  if (rst)
  begin
    wr_ptr <= {AW{1'b0}};
    rd_ptr <= {AW{1'b0}};
    count <= {(AW+1){1'b0}};
  end
  else
  begin
    if (do_wr)
      wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
    if (do_rd)
      rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
    if (do_wr && !do_rd)
      count <= count + 1'b1;
    else if (do_rd && !do_wr)
      count <= count - 1'b1;
  end
end
always @(posedge clk)
begin
  if (do_wr)
    mem[wr_ptr] <= in_data;
end
endmodule

// >>> hw/rtc_pin_sync.v
// three-stage sampler for pins from outside the clock domain, with edge pulses
`timescale 1ns/100ps
module rtc_pin_sync
(
  input wire clk,
  input wire rst,
  input wire pin,
  output reg level,
  output wire rise,
  output wire fall
);
reg s1;
reg s2;
reg s3;
// s1 feeds only s2; a change counts once s2 and s3 agree
always @(posedge clk)
begin
  if (rst)
  begin
    s1 <= 1'b0;
    s2 <= 1'b0;
    s3 <= 1'b0;
    level <= 1'b0;
  end
  else
  begin
    s1 <= pin;
    s2 <= s1;
    s3 <= s2;
    if (s2 == s3)
      level <= s3;
  end
end
assign rise = (s2 == s3) && s3 && !level;
assign fall = (s2 == s3) && !s3 && level;
endmodule

// >>> hw/rtc_serial_core.v
// serial timekeeper: three-wire link, clock/calendar registers, charger setup and scratch ram
`timescale 1ns/100ps
`include "rtc_consts.vh"
module rtc_serial_core
#(
  parameter TICK_CYCLES = (`REF_HZ / `TICK_US) * `TICK_US,
  parameter FIFO_DEPTH = 16
)
(
  input wire REF_CLK,
  input wire SYS_RST,
  input wire LINK_ENABLE,
  input wire LINK_CLK,
  input wire DATA_IN,
  output reg DATA_OUT,
  output reg DATA_OE_N,
  output wire CHARGER_ON
);
////////////////////////////////////////////////////////////////
localparam ST_CMD = 2'h0;
localparam ST_READ = 2'h1;
localparam ST_WRITE = 2'h2;
localparam ST_DONE = 2'h3;
localparam [3:0] WR_W = 4'he;

function [7:0] bcd_inc;
  input [7:0] v;
  begin
    if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  end
endfunction

function [7:0] month_days;
  input [7:0] m;
  input [7:0] y;
  reg leap;
  begin
    // bcd year divisible by four: tens even with units 0/4/8, tens odd with 2/6
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      8'h02: month_days = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
      default: month_days = 8'h31;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////
wire en_level;
wire sclk_rise;
wire sclk_fall;
wire din_level;
rtc_pin_sync u_en (.clk(REF_CLK), .rst(SYS_RST), .pin(LINK_ENABLE), .level(en_level), .rise(), .fall());
rtc_pin_sync u_sclk (.clk(REF_CLK), .rst(SYS_RST), .pin(LINK_CLK), .level(), .rise(sclk_rise), .fall(sclk_fall));
rtc_pin_sync u_din (.clk(REF_CLK), .rst(SYS_RST), .pin(DATA_IN), .level(din_level), .rise(), .fall());

reg [7:0] seconds_count;
reg [7:0] minutes_count;
reg [7:0] hours_count;
reg [7:0] day_of_month;
reg [7:0] month_count;
reg [7:0] weekday_count;
reg [7:0] year_count;
reg write_lock;
reg [7:0] charger_setup;
reg [7:0] scratch_ram [0:`RAM_WORDS-1];

reg [1:0] state;
reg [2:0] bit_cnt;
reg [7:0] shift;
reg [7:0] cmd;
reg [4:0] addr;
reg [7:0] tx_byte;
reg [7:0] burst_buf [0:7];
wire is_burst = (cmd[5:1] == `ADDR_BURST);
wire is_ram = cmd[`CMD_RAM_BIT];

function [7:0] read_reg;
  input ram_space;
  input [4:0] a;
  begin
    if (ram_space)
      read_reg = (a <= `RAM_LAST) ? scratch_ram[a] : 8'h00;
    else
      case (a)
        `IDX_SEC: read_reg = seconds_count;
        `IDX_MIN: read_reg = minutes_count;
        `IDX_HR: read_reg = hours_count;
        `IDX_DATE: read_reg = day_of_month;
        `IDX_MONTH: read_reg = month_count;
        `IDX_DAY: read_reg = weekday_count;
        `IDX_YEAR: read_reg = year_count;
        `IDX_CTRL: read_reg = {write_lock, 7'h00};
        `IDX_CHARGER: read_reg = charger_setup;
        default: read_reg = 8'h00;
      endcase
  end
endfunction

////////////////////////////////////////////////////////////////
// write requests queue through the fifo so the timekeeper applies them in order
reg wq_valid;
reg [WR_W-1:0] wq_data;
wire wq_ready;
wire wo_valid;
wire [WR_W-1:0] wo_data;
wire wo_ready;
rtc_fifo #(.WIDTH(WR_W), .DEPTH(FIFO_DEPTH), .AW(4)) u_wq (
  .clk(REF_CLK), .rst(SYS_RST), .in_valid(wq_valid), .in_ready(wq_ready), .in_data({wq_data}),
  .out_valid(wo_valid), .out_ready(wo_ready), .out_data(wo_data));
// entry layout: ram flag, full 5-bit address, 8-bit data; ram bytes 16..30 need the top address bit
reg [13:0] wq_entry;
reg wq_pending;

reg [3:0] commit_idx;
reg committing;

always @(posedge REF_CLK)
begin
  if (SYS_RST)
  begin
    state <= ST_CMD;
    bit_cnt <= 3'h0;
    shift <= 8'h00;
    cmd <= 8'h00;
    addr <= 5'h00;
    tx_byte <= 8'h00;
    DATA_OUT <= 1'b0;
    DATA_OE_N <= 1'b1;
    wq_entry <= 14'h0000;
    wq_pending <= 1'b0;
    commit_idx <= 4'h0;
    committing <= 1'b0;
  end
  else
  begin
    if (wq_pending && wq_ready)
      wq_pending <= 1'b0;
    if (committing && !wq_pending)
    begin
      // eight buffered bytes go out in address order
      wq_entry <= {1'b0, commit_idx[2:0] == 3'h0 ? `IDX_SEC : {2'b00, commit_idx[2:0]}, burst_buf[commit_idx[2:0]]};
      wq_pending <= 1'b1;
      if (commit_idx[2:0] == `CLK_BURST_LAST)
        committing <= 1'b0;
      commit_idx <= commit_idx + 4'h1;
    end
    if (!en_level)
    begin
      // link idle: pin released, partial clock burst discarded
      state <= ST_CMD;
      bit_cnt <= 3'h0;
      DATA_OE_N <= 1'b1;
      DATA_OUT <= 1'b0;
    end
    else
    begin
      if (sclk_rise)
      begin
        DATA_OE_N <= 1'b1;
        bit_cnt <= bit_cnt + 3'h1;
        shift <= {din_level, shift[7:1]};
        if (bit_cnt == `BIT_LAST)
        begin
          case (state)
            ST_CMD:
            begin
              cmd <= {din_level, shift[7:1]};
              addr <= (shift[6:2] == `ADDR_BURST) ? 5'h00 : shift[6:2];
              state <= din_level ? ((shift[1]) ? ST_READ : ST_WRITE) : ST_DONE;
              tx_byte <= read_reg(shift[7], (shift[6:2] == `ADDR_BURST) ? 5'h00 : shift[6:2]);
            end
            ST_WRITE:
            begin
              if (is_burst && !is_ram)
              begin
                burst_buf[addr[2:0]] <= {din_level, shift[7:1]};
                if (addr[2:0] == `CLK_BURST_LAST)
                begin
                  state <= ST_DONE;
                  // lock at the end of the burst blocks every byte, control too
                  if (!write_lock)
                  begin
                    committing <= 1'b1;
                    commit_idx <= 4'h0;
                  end
                end
              end
              else if (!wq_pending && !(write_lock && !(addr == `IDX_CTRL && !is_ram)) && !(is_ram && addr > `RAM_LAST))
              begin
                wq_entry <= {is_ram, addr, {din_level, shift[7:1]}};
                wq_pending <= 1'b1;
              end
              addr <= addr + 5'h1;
              if (!is_burst || (is_ram && addr == `RAM_LAST))
                state <= ST_DONE;
            end
            default:
            begin
            end
          endcase
        end
      end
      if (sclk_fall && state == ST_READ)
      begin
        DATA_OE_N <= 1'b0;
        DATA_OUT <= tx_byte[bit_cnt];
        if (bit_cnt == `BIT_LAST)
        begin
          if (is_burst)
          begin
            // clock burst wraps within 0..7, ram within 0..30
            addr <= (!is_ram && addr[2:0] == `CLK_BURST_LAST) || (is_ram && addr == `RAM_LAST) ? 5'h00 : addr + 5'h1;
            tx_byte <= read_reg(is_ram, (!is_ram && addr[2:0] == `CLK_BURST_LAST) || (is_ram && addr == `RAM_LAST)
              ? 5'h00 : addr + 5'h1);
          end
        end
      end
    end
  end
end

always @*
begin
  wq_valid = wq_pending;
  wq_data = wq_entry;
end

////////////////////////////////////////////////////////////////
reg [31:0] tick_cnt;
wire tick = (tick_cnt == TICK_CYCLES - 1);
wire halted = seconds_count[`HALT_BIT];
// applying writes stalls the tick for that cycle; one cycle of drift per applied write
assign wo_ready = 1'b1;
wire [4:0] wo_addr = wo_data[12:8];
wire [7:0] wo_byte = wo_data[7:0];
wire wo_ram = wo_data[13];
wire [7:0] hr_max = hours_count[`MODE12_BIT] ? 8'h12 : 8'h23;
wire [7:0] hr_units = {2'b00, hours_count[`MODE12_BIT] ? 1'b0 : hours_count[`PM_BIT], hours_count[4:0]};
wire [7:0] hr12_inc = bcd_inc({3'h0, hours_count[4:0]});
wire [7:0] hr24_inc = bcd_inc({2'b00, hours_count[5:0]});
reg [7:0] next_hr;
integer i;

always @*
begin
  // 12-hour: 11->12 flips pm, 12->01; 24-hour: 23->00
  next_hr = hours_count;
  if (hours_count[`MODE12_BIT])
  begin
    if (hr_units[5:0] == 6'h12)
      next_hr = {hours_count[7:6], hours_count[`PM_BIT], 5'h01};
    else if (hr_units[5:0] == 6'h11)
      next_hr = {hours_count[7:6], ~hours_count[`PM_BIT], 5'h12};
    else
      next_hr = {hours_count[7:5], hr12_inc[4:0]};
  end
  else if (hr_units == hr_max)
    next_hr = {hours_count[7:6], 6'h00};
  else
    next_hr = {hours_count[7:6], hr24_inc[5:0]};
end

always @(posedge REF_CLK)
begin
  if (SYS_RST)
  begin
    tick_cnt <= 32'h0;
    seconds_count <= `SEC_RESET;
    minutes_count <= 8'h00;
    hours_count <= 8'h00;
    day_of_month <= `DATE_RESET;
    month_count <= `MONTH_RESET;
    weekday_count <= `DAY_RESET;
    year_count <= 8'h00;
    write_lock <= 1'b1;
    charger_setup <= `CHARGER_RESET;
    for (i = 0; i < `RAM_WORDS; i = i + 1)
      scratch_ram[i] <= 8'h00;
  end
  else if (wo_valid)
  begin
    if (wo_ram)
      scratch_ram[wo_addr] <= wo_byte;
    else
      case (wo_addr)
        `IDX_SEC: seconds_count <= wo_byte;
        `IDX_MIN: minutes_count <= {1'b0, wo_byte[6:0]};
        `IDX_HR: hours_count <= {wo_byte[7], 1'b0, wo_byte[5:0]};
        `IDX_DATE: day_of_month <= {2'b00, wo_byte[5:0]};
        `IDX_MONTH: month_count <= {3'h0, wo_byte[4:0]};
        `IDX_DAY: weekday_count <= {5'h00, wo_byte[2:0]};
        `IDX_YEAR: year_count <= wo_byte;
        `IDX_CTRL: write_lock <= wo_byte[`LOCK_BIT];
        `IDX_CHARGER: charger_setup <= wo_byte;
        default:
        begin
        end
      endcase
  end
  else if (halted)
    tick_cnt <= 32'h0;
  else if (!tick)
    tick_cnt <= tick_cnt + 32'h1;
  else
  begin
    tick_cnt <= 32'h0;
    // bcd ripple carry through the calendar
    if (seconds_count[6:0] != 7'h59)
      seconds_count <= bcd_inc(seconds_count);
    else
    begin
      seconds_count <= 8'h00;
      if (minutes_count != 8'h59)
        minutes_count <= bcd_inc(minutes_count);
      else
      begin
        minutes_count <= 8'h00;
        hours_count <= next_hr;
        if ((!hours_count[`MODE12_BIT] && hr_units == 8'h23) ||
          (hours_count[`MODE12_BIT] && hours_count[`PM_BIT] && hr_units[5:0] == 6'h11))
        begin
          weekday_count <= (weekday_count == 8'h07) ? 8'h01 : bcd_inc(weekday_count);
          if (day_of_month != month_days(month_count, year_count))
            day_of_month <= bcd_inc(day_of_month);
          else
          begin
            day_of_month <= 8'h01;
            if (month_count != 8'h12)
              month_count <= bcd_inc(month_count);
            else
            begin
              month_count <= 8'h01;
              year_count <= (year_count == 8'h99) ? 8'h00 : bcd_inc(year_count);
            end
          end
        end
      end
    end
  end
end

// only the 1010 pattern with a real diode and resistor choice turns the charger on
assign CHARGER_ON = (charger_setup[7:4] == 4'ha) && (charger_setup[3:2] == 2'b01 || charger_setup[3:2] == 2'b10)
  && (charger_setup[1:0] != 2'b00);
endmodule

// >>> sim/rtc_link_sva.sv
// pin-level assertions for the serial timekeeper
`timescale 1ns/100ps
module rtc_link_sva
#(
  parameter TICK_CYCLES = 20,
  parameter FIFO_DEPTH = 16
)
(
  input wire REF_CLK,
  input wire SYS_RST,
  input wire LINK_ENABLE,
  input wire LINK_CLK,
  input wire DATA_IN,
  input wire DATA_OUT,
  input wire DATA_OE_N,
  input wire CHARGER_ON
);
  logic [3:0] rises;
  default clocking dc @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);
  // raw edges count ahead of the design's sampler, so a bound of 8 is safe
  always @(posedge REF_CLK)
  begin
    if (SYS_RST || !LINK_ENABLE)
      rises <= 4'h0;
    else if ($rose(LINK_CLK) && rises != 4'hf)
      rises <= rises + 4'h1;
  end
  ////////////////////////////////////////
  sequence driven_rise;
    $rose(LINK_CLK) && !DATA_OE_N;
  endsequence
  sequence let_go;
    ##[1:6] DATA_OE_N;
  endsequence
  drive_on_fall_a: assert property ($fell(DATA_OE_N) |-> !$past(LINK_CLK, 2))
    else $error("data driven outside the link low half");
  release_on_rise_a: assert property (driven_rise |-> let_go)
    else $error("data not released after link rise");
  release_on_idle_a: assert property ($fell(LINK_ENABLE) |-> let_go)
    else $error("data not released after enable low");
  quiet_when_idle_a: assert property (!LINK_ENABLE [*8] |-> DATA_OE_N)
    else $error("data driven with enable low");
  bit_holds_a: assert property (!DATA_OE_N && !$past(DATA_OE_N) |-> $stable(DATA_OUT))
    else $error("read bit changed while driven");
  command_first_a: assert property ($fell(DATA_OE_N) |-> rises >= 4'h8)
    else $error("data driven before eight command bits");
  drive_in_frame_a: assert property (!DATA_OE_N |-> $past(LINK_ENABLE, 6))
    else $error("data driven without a transfer");
  charger_quiet_a: assert property ($changed(CHARGER_ON) |-> LINK_ENABLE || $past(LINK_ENABLE, 8))
    else $error("charger changed without a write");
endmodule

// >>> sim/rtc_host_model.sv
// microprocessor side of the three-wire link
`timescale 1ns/100ps
module rtc_host_model
(
  output logic link_enable,
  output logic link_clk,
  output logic host_data,
  output logic host_oe,
  input wire io_level
);
  initial
  begin
    link_enable = 1'b0;
    link_clk = 1'b0;
    host_data = 1'b0;
    host_oe = 1'b0;
  end
  ////////////////////////////////////////
  // clock is low when enable rises; pause covers the sampler delay
  task start;
  begin
    link_enable = 1'b1;
    #1000;
  end
  endtask
  // enable held past the last rise so a burst can commit
  task stop;
  begin
    #400;
    host_oe = 1'b0;
    link_enable = 1'b0;
    #1200;
  end
  endtask
  // lsb first, set on the low half, read just after the rise
  task xfer(input [7:0] tx, input drive, output [7:0] rx);
    integer i;
  begin
    for (i = 0; i < 8; i = i + 1)
    begin
      host_oe = drive;
      host_data = tx[i];
      #400;
      link_clk = 1'b1;
      #50;
      rx[i] = io_level;
      #350;
      link_clk = 1'b0;
    end
  end
  endtask
endmodule

// >>> sim/tb.sv
// register access tests over the three-wire link
`timescale 1ns/100ps
module tb;
  localparam TICK = 2000;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  wire link_enable, link_clk, host_data, host_oe, data_out, data_oe_n, charger_on, io;
  integer errors = 0;
  integer checks = 0;
  integer i;
  logic [7:0] v;
  logic [7:0] s [0:31];
  logic [7:0] chg [0:4] = '{8'ha5, 8'hab, 8'ha4, 8'hac, 8'h55};
  // released line falls to its pull-down
  assign io = !data_oe_n ? data_out : (host_oe ? host_data : 1'b0);
  always #50 ref_clk = ~ref_clk;
  rtc_serial_core #(.TICK_CYCLES(TICK), .FIFO_DEPTH(16)) u_dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
    .LINK_ENABLE(link_enable), .LINK_CLK(link_clk), .DATA_IN(io), .DATA_OUT(data_out),
    .DATA_OE_N(data_oe_n), .CHARGER_ON(charger_on));
  rtc_host_model u_host (.link_enable(link_enable), .link_clk(link_clk), .host_data(host_data),
    .host_oe(host_oe), .io_level(io));
  ////////////////////////////////////////
  function [7:0] cmd(input ram, input [4:0] a, input rd);
    cmd = {1'b1, ram, a, rd};
  endfunction
  task check8(input string name, input [7:0] exp, input [7:0] got);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  end
  endtask
  task wr(input [7:0] c, input [7:0] d);
  begin
    u_host.start;
    u_host.xfer(c, 1'b1, v);
    u_host.xfer(d, 1'b1, v);
    u_host.stop;
  end
  endtask
  task rd(input [7:0] c, output [7:0] d);
  begin
    u_host.start;
    u_host.xfer(c, 1'b1, v);
    u_host.xfer(8'h00, 1'b0, d);
    u_host.stop;
  end
  endtask
  task burst_wr(input [7:0] c, input integer n);
    integer k;
  begin
    u_host.start;
    u_host.xfer(c, 1'b1, v);
    for (k = 0; k < n; k = k + 1)
      u_host.xfer(s[k], 1'b1, v);
    u_host.stop;
  end
  endtask
  // reads past the end must wrap to the first byte
  task burst_check(input [7:0] c, input integer n, input integer w);
    integer k;
    logic [7:0] r;
  begin
    u_host.start;
    u_host.xfer(c, 1'b1, v);
    for (k = 0; k < n; k = k + 1)
    begin
      u_host.xfer(8'h00, 1'b0, r);
      check8("burst_byte", s[k % w], r);
    end
    u_host.stop;
  end
  endtask
  task results;
  begin
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  initial
  begin
    #3000000;
    errors = errors + 1;
    results;
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    rd(cmd(0, 7, 1), v);
    check8("ctrl_reset", 8'h80, v);
    rd(cmd(0, 8, 1), v);
    check8("charger_reset", 8'h5c, v);
    wr(cmd(1, 0, 0), 8'h55);
    rd(cmd(1, 0, 1), v);
    check8("ram_locked", 8'h00, v);
    wr(cmd(0, 7, 0), 8'hff);
    rd(cmd(0, 7, 1), v);
    check8("ctrl_low_zero", 8'h80, v);
    wr(cmd(0, 7, 0), 8'h00);
    rd(cmd(0, 7, 1), v);
    check8("ctrl_clear", 8'h00, v);
    wr(8'h42, 8'h66);
    rd(cmd(1, 1, 1), v);
    check8("no_start_bit", 8'h00, v);
    for (i = 0; i < 5; i = i + 1)
    begin
      wr(cmd(0, 8, 0), chg[i]);
      rd(cmd(0, 8, 1), v);
      check8("charger_rd", chg[i], v);
      check8("charger_on", {7'h00, i < 2}, {7'h00, charger_on});
    end
    // halted seconds keep the burst image still while it is read
    s = '{0: 8'hd8, 1: 8'h59, 2: 8'h23, 3: 8'h28, 4: 8'h02, 5: 8'h07, default: 8'h00};
    burst_wr(cmd(0, 31, 0), 8);
    burst_check(cmd(0, 31, 1), 9, 8);
    s[1] = 8'h11;
    burst_wr(cmd(0, 31, 0), 4);
    wr(cmd(0, 7, 0), 8'h80);
    s[7] = 8'h00;
    burst_wr(cmd(0, 31, 0), 8);
    s[1] = 8'h59;
    s[7] = 8'h80;
    burst_check(cmd(0, 31, 1), 8, 8);
    wr(cmd(0, 7, 0), 8'h00);
    // 23:59:59 on the 28th of february in a leap year
    wr(cmd(0, 0, 0), 8'h59);
    #250000;
    rd(cmd(0, 3, 1), v);
    check8("leap_date", 8'h29, v);
    rd(cmd(0, 2, 1), v);
    check8("hour_wrap", 8'h00, v);
    rd(cmd(0, 1, 1), v);
    check8("minute_wrap", 8'h00, v);
    rd(cmd(0, 5, 1), v);
    check8("weekday_wrap", 8'h01, v);
    rd(cmd(0, 4, 1), v);
    check8("month_kept", 8'h02, v);
    // halt first so the second's prescaler restarts from zero at the last write
    wr(cmd(0, 0, 0), 8'hd9);
    wr(cmd(0, 1, 0), 8'h59);
    // 11:59:59 pm in 12-hour format on the 29th of february
    wr(cmd(0, 2, 0), 8'hb1);
    wr(cmd(0, 0, 0), 8'h59);
    #250000;
    rd(cmd(0, 2, 1), v);
    check8("pm_wrap", 8'h92, v);
    rd(cmd(0, 3, 1), v);
    check8("month_end_date", 8'h01, v);
    rd(cmd(0, 4, 1), v);
    check8("month_next", 8'h03, v);
    for (i = 0; i < 31; i = i + 1)
      s[i] = 8'h10 + 8'h07 * i[7:0];
    burst_wr(cmd(1, 31, 0), 31);
    burst_check(cmd(1, 31, 1), 32, 31);
    rd(cmd(1, 30, 1), v);
    check8("ram_last", s[30], v);
    results;
  end
endmodule
bind rtc_serial_core rtc_link_sva #(.TICK_CYCLES(TICK_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) u_sva (.REF_CLK(REF_CLK),
  .SYS_RST(SYS_RST), .LINK_ENABLE(LINK_ENABLE), .LINK_CLK(LINK_CLK), .DATA_IN(DATA_IN),
  .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N), .CHARGER_ON(CHARGER_ON));
